// >>> scp_pkg.sv
// package of constants for the sensor clock and power register bank
// assumes word addressed 16-bit registers reached over the serial configuration port
// Notes on behaviour
// - io config bit 0 powers clock input receiver
// - clock config bit 0 enables analogue clocks
// - clock config bit 2 selects synthesizer source
// - clock config bit 3 selects divide by four
// - clock config at word 32 resets 0x0004
// - word 34 bit 0 is general logic enable
// - word 40 bit 0 powers pixel array
// - soft reset value 0x9 holds clock generator
package scp_pkg;
  localparam int ADDR_W = 9;
  localparam int DATA_W = 16;
  localparam int FRAME_ADDR_BITS = 10; // address bits plus write flag
  // word addresses
  localparam logic [8:0] ADR_IO_PAD_CONFIG = 9'h014;
  localparam logic [8:0] ADR_SYNTH_LOCK_STATUS = 9'h018;
  localparam logic [8:0] ADR_RSV_LOCK_TUNING_A = 9'h01A;
  localparam logic [8:0] ADR_RSV_LOCK_TUNING_B = 9'h01B;
  localparam logic [8:0] ADR_CLOCK_GEN_CONFIG = 9'h020;
  localparam logic [8:0] ADR_LOGIC_ENABLE_CONFIG = 9'h022;
  localparam logic [8:0] ADR_RSV_LOGIC_A = 9'h026;
  localparam logic [8:0] ADR_RSV_LOGIC_B = 9'h027;
  localparam logic [8:0] ADR_PIXEL_ARRAY_POWER = 9'h028;
  // reset values
  localparam logic [15:0] RST_IO_PAD_CONFIG = 16'h0000;
  localparam logic [15:0] RST_RSV_LOCK_TUNING_A = 16'h2280;
  localparam logic [15:0] RST_RSV_LOCK_TUNING_B = 16'h3D2D;
  localparam logic [15:0] RST_CLOCK_GEN_CONFIG = 16'h0004;
  localparam logic [15:0] RST_LOGIC_ENABLE_CONFIG = 16'h0000;
  localparam logic [15:0] RST_RSV_LOGIC = 16'h0000;
  localparam logic [15:0] RST_PIXEL_ARRAY_POWER = 16'h0000;
  // field positions
  localparam int BIT_CLOCK_IN_PWR = 0;
  localparam int BIT_LOCK = 0;
  localparam int BIT_EN_ANALOG = 0;
  localparam int BIT_EN_LOGIC = 1;
  localparam int BIT_SEL_SYNTH = 2;
  localparam int BIT_DIV_BY4 = 3;
  localparam int BIT_MUX_LO = 4;
  localparam int BIT_MUX_HI = 5;
  localparam int BIT_LOGIC_EN = 0;
  localparam int BIT_PIXEL_PWR = 0;
  // clock generator soft reset hold code
  localparam logic [3:0] CGEN_SOFT_RESET_HOLD = 4'h9;
  // serial port sequencer
  typedef enum logic [1:0] {
    SCP_IDLE = 2'b00,
    SCP_ADDR = 2'b01,
    SCP_DATA = 2'b11
  } scp_state_type;
endpackage : scp_pkg

// >>> scp_cfg_if.sv
// carrier between the serial port front end and the register bank
// assumes one clock; strobes are single-cycle pulses on clk_sys
`timescale 1ns/1ns
interface scp_cfg_if;
  logic req_wr; // write strobe, one cycle
  logic req_rd; // read strobe, one cycle
  logic [8:0] addr; // word address
  logic [15:0] wdata; // write data
  logic [15:0] rdata; // read data, valid the cycle after req_rd
  modport port_side (output req_wr, output req_rd, output addr, output wdata, input rdata);
  modport reg_side (input req_wr, input req_rd, input addr, input wdata, output rdata);
endinterface : scp_cfg_if

// >>> scp_serial_port.sv
// serial configuration port front end: mode 0, 9-bit address, write flag, 16 data bits
// assumes spi pins are asynchronous and sck runs at most clk_sys / 8
`timescale 1ns/1ns
module scp_serial_port
  import scp_pkg::*;
(
  input wire logic clk_sys, // system clock
  input wire logic rst_n, // synchronised reset, active low
  input wire logic spi_sck, // serial clock pin
  input wire logic spi_ss_n, // select pin, active low
  input wire logic spi_mosi, // serial data in pin
  output logic spi_miso, // serial data out
  scp_cfg_if.port_side cfg // register strobes
);
  logic sck_meta_r, sck_s_r, sck_d_r, ss_meta_r, ss_s_r, mosi_meta_r, mosi_s_r;
  logic sck_rise, sck_fall;
  scp_state_type state_r, state_nxt;
  logic [4:0] cnt_r, cnt_nxt;
  logic [9:0] ahdr_r, ahdr_nxt;
  logic [15:0] sin_r, sin_nxt, sout_r, sout_nxt;
  logic wr_r, wr_nxt, miso_r, miso_nxt, req_wr_r, req_wr_nxt, req_rd_r, req_rd_nxt, load_r;

  // two stages before any logic reads a pin
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      {sck_meta_r, sck_s_r, sck_d_r} <= 3'h0;
      {ss_meta_r, ss_s_r} <= 2'h3;
      {mosi_meta_r, mosi_s_r} <= 2'h0;
    end else begin
      sck_meta_r <= spi_sck;
      sck_s_r <= sck_meta_r;
      sck_d_r <= sck_s_r;
      ss_meta_r <= spi_ss_n;
      ss_s_r <= ss_meta_r;
      mosi_meta_r <= spi_mosi;
      mosi_s_r <= mosi_meta_r;
    end
  end

  assign sck_rise = sck_s_r & ~sck_d_r;
  assign sck_fall = ~sck_s_r & sck_d_r;

  // frame sequencer: sample on rising sck, shift out on falling sck
  always_comb begin
    state_nxt = state_r;
    cnt_nxt = cnt_r;
    ahdr_nxt = ahdr_r;
    sin_nxt = sin_r;
    sout_nxt = sout_r;
    wr_nxt = wr_r;
    miso_nxt = miso_r;
    req_wr_nxt = 1'b0;
    req_rd_nxt = 1'b0;
    if (load_r) begin
      sout_nxt = cfg.rdata; // read data lands before the first falling edge
    end
    if (ss_s_r) begin
      state_nxt = SCP_IDLE; // deselect aborts a partial frame, no write issued
      miso_nxt = 1'b0;
    end else begin
      unique case (state_r)
        SCP_IDLE: begin
          state_nxt = SCP_ADDR;
          cnt_nxt = 5'h00;
        end
        SCP_ADDR: begin
          if (sck_rise) begin
            ahdr_nxt = {ahdr_r[8:0], mosi_s_r};
            cnt_nxt = cnt_r + 5'h01;
            if (cnt_r == 5'(FRAME_ADDR_BITS - 1)) begin
              wr_nxt = mosi_s_r;
              req_rd_nxt = ~mosi_s_r;
              state_nxt = SCP_DATA;
              cnt_nxt = 5'h00;
            end
          end
        end
        SCP_DATA: begin
          if (sck_fall) begin
            miso_nxt = wr_r ? 1'b0 : sout_r[15];
            sout_nxt = {sout_r[14:0], 1'b0};
          end
          if (sck_rise && cnt_r != 5'(DATA_W)) begin
            sin_nxt = {sin_r[14:0], mosi_s_r};
            cnt_nxt = cnt_r + 5'h01;
            req_wr_nxt = wr_r && (cnt_r == 5'(DATA_W - 1)); // extra clocks are ignored
          end
        end
      endcase
    end
  end

  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      state_r <= SCP_IDLE;
      cnt_r <= 5'h00;
      ahdr_r <= 10'h000;
      sin_r <= 16'h0000;
      sout_r <= 16'h0000;
      wr_r <= 1'b0;
      miso_r <= 1'b0;
      req_wr_r <= 1'b0;
      req_rd_r <= 1'b0;
      load_r <= 1'b0;
    end else begin
      state_r <= state_nxt;
      cnt_r <= cnt_nxt;
      ahdr_r <= ahdr_nxt;
      sin_r <= sin_nxt;
      sout_r <= sout_nxt;
      wr_r <= wr_nxt;
      miso_r <= miso_nxt;
      req_wr_r <= req_wr_nxt;
      req_rd_r <= req_rd_nxt;
      load_r <= req_rd_r;
    end
  end

  assign cfg.req_wr = req_wr_r;
  assign cfg.req_rd = req_rd_r;
  assign cfg.addr = ahdr_r[9:1];
  assign cfg.wdata = sin_r;
  assign spi_miso = miso_r;
endmodule : scp_serial_port

// >>> scp_regs_top.sv
// sensor clock and power register bank with its serial configuration port
// assumes synth_lock is asynchronous and cgen_soft_reset comes from logic on clk_sys
`timescale 1ns/1ns
module scp_regs_top
  import scp_pkg::*;
(
  input wire logic clk_sys, // 20 MHz system clock
  input wire logic reset_n, // asynchronous reset, active low
  input wire logic spi_sck, // serial clock
  input wire logic spi_ss_n, // serial select, active low
  input wire logic spi_mosi, // serial data in
  output logic spi_miso, // serial data out
  input wire logic synth_lock, // synthesizer lock detector
  input wire logic [3:0] cgen_soft_reset, // clock generator soft reset field
  output logic clock_in_power_up, // clock input receiver powered
  output logic analog_clk_en, // analogue clocks running
  output logic logic_clk_en, // logic clock running
  output logic clk_src_synth, // 1 synthesizer, 0 serial clock input
  output logic div_by4, // 1 divide by 4, 0 divide by 5
  output logic [1:0] lane_mux, // lane multiplex mode
  output logic logic_enable, // general logic enable
  output logic pixel_array_power_up // pixel array powered
);
  logic rst_meta_r, rst_n_r;
  logic lock_meta_r, lock_s_r;
  logic [15:0] io_r, io_nxt, tune_a_r, tune_a_nxt, tune_b_r, tune_b_nxt;
  logic [15:0] cgen_r, cgen_nxt, logen_r, logen_nxt, rsv_a_r, rsv_a_nxt;
  logic [15:0] rsv_b_r, rsv_b_nxt, pix_r, pix_nxt, rdata_r, rdata_nxt;
  logic ana_en_r, ana_en_nxt, log_en_r, log_en_nxt, cgen_run;

  scp_cfg_if cfg ();

  scp_serial_port u_port (
    .clk_sys(clk_sys),
    .rst_n(rst_n_r),
    .spi_sck(spi_sck),
    .spi_ss_n(spi_ss_n),
    .spi_mosi(spi_mosi),
    .spi_miso(spi_miso),
    .cfg(cfg.port_side)
  );

  // reset release through two stages so every flop leaves reset on the same edge
  always_ff @(posedge clk_sys or negedge reset_n) begin
    if (!reset_n) begin
      rst_meta_r <= 1'b0;
      rst_n_r <= 1'b0;
    end else begin
      rst_meta_r <= 1'b1;
      rst_n_r <= rst_meta_r;
    end
  end

  // lock comes from an analogue detector, so synchronise it
  always_ff @(posedge clk_sys or negedge rst_n_r) begin
    if (!rst_n_r) begin
      lock_meta_r <= 1'b0;
      lock_s_r <= 1'b0;
    end else begin
      lock_meta_r <= synth_lock;
      lock_s_r <= lock_meta_r;
    end
  end

  // clock generator leaves soft reset for any code but the hold code
  assign cgen_run = (cgen_soft_reset != CGEN_SOFT_RESET_HOLD);

  // register writes and read mux; reserved words are stored as written
  always_comb begin
    io_nxt = io_r;
    tune_a_nxt = tune_a_r;
    tune_b_nxt = tune_b_r;
    cgen_nxt = cgen_r;
    logen_nxt = logen_r;
    rsv_a_nxt = rsv_a_r;
    rsv_b_nxt = rsv_b_r;
    pix_nxt = pix_r;
    rdata_nxt = rdata_r;
    if (cfg.req_wr) begin
      unique case (cfg.addr)
        ADR_IO_PAD_CONFIG: io_nxt = cfg.wdata;
        ADR_RSV_LOCK_TUNING_A: tune_a_nxt = cfg.wdata;
        ADR_RSV_LOCK_TUNING_B: tune_b_nxt = cfg.wdata;
        ADR_CLOCK_GEN_CONFIG: cgen_nxt = cfg.wdata;
        ADR_LOGIC_ENABLE_CONFIG: logen_nxt = cfg.wdata;
        ADR_RSV_LOGIC_A: rsv_a_nxt = cfg.wdata;
        ADR_RSV_LOGIC_B: rsv_b_nxt = cfg.wdata;
        ADR_PIXEL_ARRAY_POWER: pix_nxt = cfg.wdata;
        default: ; // unmapped and read-only words ignore writes
      endcase
    end
    if (cfg.req_rd) begin
      unique case (cfg.addr)
        ADR_IO_PAD_CONFIG: rdata_nxt = io_r;
        ADR_SYNTH_LOCK_STATUS: rdata_nxt = {15'h0000, lock_s_r};
        ADR_RSV_LOCK_TUNING_A: rdata_nxt = tune_a_r;
        ADR_RSV_LOCK_TUNING_B: rdata_nxt = tune_b_r;
        ADR_CLOCK_GEN_CONFIG: rdata_nxt = cgen_r;
        ADR_LOGIC_ENABLE_CONFIG: rdata_nxt = logen_r;
        ADR_RSV_LOGIC_A: rdata_nxt = rsv_a_r;
        ADR_RSV_LOGIC_B: rdata_nxt = rsv_b_r;
        ADR_PIXEL_ARRAY_POWER: rdata_nxt = pix_r;
        default: rdata_nxt = 16'h0000; // unmapped words read zero
      endcase
    end
    // clock enables are forced off while the generator is held in soft reset
    ana_en_nxt = cgen_nxt[BIT_EN_ANALOG] & cgen_run;
    log_en_nxt = cgen_nxt[BIT_EN_LOGIC] & cgen_run;
  end

  always_ff @(posedge clk_sys or negedge rst_n_r) begin
    if (!rst_n_r) begin
      io_r <= RST_IO_PAD_CONFIG;
      tune_a_r <= RST_RSV_LOCK_TUNING_A;
      tune_b_r <= RST_RSV_LOCK_TUNING_B;
      cgen_r <= RST_CLOCK_GEN_CONFIG;
      logen_r <= RST_LOGIC_ENABLE_CONFIG;
      rsv_a_r <= RST_RSV_LOGIC;
      rsv_b_r <= RST_RSV_LOGIC;
      pix_r <= RST_PIXEL_ARRAY_POWER;
      rdata_r <= 16'h0000;
      ana_en_r <= 1'b0;
      log_en_r <= 1'b0;
    end else begin
      io_r <= io_nxt;
      tune_a_r <= tune_a_nxt;
      tune_b_r <= tune_b_nxt;
      cgen_r <= cgen_nxt;
      logen_r <= logen_nxt;
      rsv_a_r <= rsv_a_nxt;
      rsv_b_r <= rsv_b_nxt;
      pix_r <= pix_nxt;
      rdata_r <= rdata_nxt;
      ana_en_r <= ana_en_nxt;
      log_en_r <= log_en_nxt;
    end
  end

  assign cfg.rdata = rdata_r;

  // outputs come straight from register bits, the two clock enables from flops gated by the soft reset
  assign clock_in_power_up = io_r[BIT_CLOCK_IN_PWR];
  assign analog_clk_en = ana_en_r;
  assign logic_clk_en = log_en_r;
  assign clk_src_synth = cgen_r[BIT_SEL_SYNTH];
  assign div_by4 = cgen_r[BIT_DIV_BY4];
  assign lane_mux = cgen_r[BIT_MUX_HI:BIT_MUX_LO];
  assign logic_enable = logen_r[BIT_LOGIC_EN];
  assign pixel_array_power_up = pix_r[BIT_PIXEL_PWR];
endmodule : scp_regs_top

// >>> scp_regs_props.sv
// checker for the clock and power register bank ports
// assumes it is bound onto scp_regs_top and sees its ports only
`timescale 1ns/1ns
module scp_regs_props
  import scp_pkg::*;
(
  input wire logic clk_sys, // clock
  input wire logic reset_n, // reset, active low
  input wire logic spi_sck, // serial clock
  input wire logic spi_ss_n, // select, active low
  input wire logic spi_mosi, // data in
  input wire logic spi_miso, // data out
  input wire logic synth_lock, // lock input
  input wire logic [3:0] cgen_soft_reset, // soft reset field
  input wire logic clock_in_power_up, // receiver power
  input wire logic analog_clk_en, // analogue clocks
  input wire logic logic_clk_en, // logic clock
  input wire logic clk_src_synth, // source select
  input wire logic div_by4, // divider mode
  input wire logic [1:0] lane_mux, // mux mode
  input wire logic logic_enable, // logic enable
  input wire logic pixel_array_power_up // array power
);
  default clocking @(posedge clk_sys); endclocking
  default disable iff (!reset_n);
  // hold code from the neighbour block
  wire hold = (cgen_soft_reset == CGEN_SOFT_RESET_HOLD);
  // outputs still carry reset values at the first edge after release
  a_reset_clock_defaults: assert property ($rose(reset_n) |-> clk_src_synth && !analog_clk_en
    && !logic_clk_en && !div_by4 && lane_mux == 2'h0) else $error("clock outputs not at reset values");
  a_reset_power_defaults: assert property ($rose(reset_n) |-> !clock_in_power_up
    && !logic_enable && !pixel_array_power_up) else $error("power outputs not at reset values");
  a_hold_analog_off: assert property (hold [*2] |-> !analog_clk_en)
    else $error("analogue clocks run in hold");
  a_hold_logic_off: assert property (hold [*2] |-> !logic_clk_en)
    else $error("logic clock runs in hold");
  a_analog_rise_cause: assert property ($rose(analog_clk_en) |-> !$past(hold))
    else $error("analogue rose in hold");
  a_logic_rise_cause: assert property ($rose(logic_clk_en) |-> !$past(hold))
    else $error("logic clock rose in hold");
  // without a frame no configuration output but the two clock enables may move
  a_config_quiet: assert property (spi_ss_n [*8] |-> $stable(clk_src_synth) && $stable(div_by4)
    && $stable(lane_mux)) else $error("clock config moved without a frame");
  a_power_quiet: assert property (spi_ss_n [*8] |-> $stable(clock_in_power_up)
    && $stable(logic_enable) && $stable(pixel_array_power_up)) else $error("power output moved without a frame");
  c_source_serial: cover property ($fell(clk_src_synth));
  c_hold_leave: cover property (hold ##1 !hold);
  c_array_up: cover property ($rose(pixel_array_power_up));
endmodule : scp_regs_props
bind scp_regs_top scp_regs_props scp_regs_props_i (.clk_sys, .reset_n, .spi_sck, .spi_ss_n, .spi_mosi, .spi_miso,
  .synth_lock, .cgen_soft_reset, .clock_in_power_up, .analog_clk_en, .logic_clk_en, .clk_src_synth, .div_by4,
  .lane_mux, .logic_enable, .pixel_array_power_up);

// >>> testbench.sv
// self-checking bench for the clock and power register bank
// assumes one 20 MHz clock; frames are bit-banged on the serial pins
`timescale 1ns/1ns
module testbench;
  import scp_pkg::*;
  logic clk_sys = 0;
  logic reset_n = 0;
  logic spi_sck = 0;
  logic spi_ss_n = 1;
  logic spi_mosi = 0;
  logic synth_lock = 0;
  logic [3:0] cgen_soft_reset = 4'h9;
  logic spi_miso, clock_in_power_up, analog_clk_en, logic_clk_en, clk_src_synth, div_by4, logic_enable;
  logic pixel_array_power_up;
  logic [1:0] lane_mux;
  logic [15:0] rv;
  int err_total = 0;
  int tests_run = 0;
  logic [8:0] adr [9] = '{ADR_IO_PAD_CONFIG, ADR_SYNTH_LOCK_STATUS, ADR_RSV_LOCK_TUNING_A, ADR_RSV_LOCK_TUNING_B,
    ADR_CLOCK_GEN_CONFIG, ADR_LOGIC_ENABLE_CONFIG, ADR_RSV_LOGIC_A, ADR_RSV_LOGIC_B, ADR_PIXEL_ARRAY_POWER};
  logic [15:0] dflt [9] = '{16'h0000, 16'h0000, 16'h2280, 16'h3D2D, 16'h0004, 16'h0000, 16'h0000, 16'h0000, 16'h0000};
  logic [15:0] cv [4] = '{16'h0005, 16'h0006, 16'h0004, 16'h003B};
  logic [15:0] ov [4] = '{16'h00A0, 16'h0060, 16'h0020, 16'h00DC};
  // all outputs but spi_miso packed: power, analogue, logic, source, divider, mux, enable, array
  wire [15:0] outs = {7'h00, clock_in_power_up, analog_clk_en, logic_clk_en, clk_src_synth, div_by4, lane_mux,
    logic_enable, pixel_array_power_up};
  always #25 clk_sys = ~clk_sys;
  scp_regs_top scp_regs_top_i (.clk_sys, .reset_n, .spi_sck, .spi_ss_n, .spi_mosi, .spi_miso, .synth_lock,
    .cgen_soft_reset, .clock_in_power_up, .analog_clk_en, .logic_clk_en, .clk_src_synth, .div_by4, .lane_mux,
    .logic_enable, .pixel_array_power_up);
  // inputs always move 5 ns after a rising edge
  task automatic cyc(input int n);
    repeat (n) @(posedge clk_sys);
    #5;
  endtask : cyc
  task automatic chk(input string nm, input logic [15:0] got, input logic [15:0] exp);
    tests_run++;
    if (got !== exp) begin
      err_total++;
      $display("[ERR] %s expected %h seen %h", nm, exp, got);
    end
  endtask : chk
  // one frame msb first; sck half periods of 5 clocks keep well inside the sync limit; nb < 26 aborts
  task automatic xfer(input logic [8:0] a, input logic w, input logic [15:0] d, input int nb, output logic [15:0] q);
    logic [25:0] f;
    f = {a, w, d};
    q = 16'h0000;
    spi_ss_n = 0;
    cyc(5);
    for (int i = 25; i >= 26 - nb; i--) begin
      spi_mosi = f[i];
      cyc(5);
      spi_sck = 1;
      if (i < 16) q[i] = spi_miso;
      cyc(5);
      spi_sck = 0;
    end
    cyc(5);
    spi_ss_n = 1;
    cyc(8);
  endtask : xfer
  task automatic wr(input logic [8:0] a, input logic [15:0] d);
    xfer(a, 1'b1, d, 26, rv);
  endtask : wr
  task automatic rd(input string nm, input logic [8:0] a, input logic [15:0] exp);
    xfer(a, 1'b0, 16'h0000, 26, rv);
    chk(nm, rv, exp);
  endtask : rd
  task automatic finish_test;
    $display("checks %0d mismatches %0d", tests_run, err_total);
    if (err_total == 0 && tests_run > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask : finish_test
  // a hang is cut short well past the expected run of about 8000 clocks
  initial begin
    repeat (30000) @(posedge clk_sys);
    err_total++;
    finish_test;
  end
  // main sequence
  initial begin
    cyc(4);
    reset_n = 1;
    cyc(8);
    chk("outs", outs, 16'h0020);
    for (int k = 0; k < 9; k++) rd("reg", adr[k], dflt[k]);
    $display("test reset values done");
    synth_lock = 1;
    cyc(4);
    rd("lock", ADR_SYNTH_LOCK_STATUS, 16'h0001);
    wr(ADR_SYNTH_LOCK_STATUS, 16'hFFFE);
    rd("lock", ADR_SYNTH_LOCK_STATUS, 16'h0001);
    synth_lock = 0;
    cyc(4);
    rd("lock", ADR_SYNTH_LOCK_STATUS, 16'h0000);
    $display("test lock done");
    cgen_soft_reset = 4'h0;
    for (int k = 0; k < 4; k++) begin
      wr(ADR_CLOCK_GEN_CONFIG, cv[k]);
      chk("outs", outs, ov[k]);
      rd("cgen", ADR_CLOCK_GEN_CONFIG, cv[k]);
    end
    cgen_soft_reset = 4'h9;
    cyc(3);
    chk("outs", outs, 16'h001C);
    rd("cgen", ADR_CLOCK_GEN_CONFIG, 16'h003B);
    cgen_soft_reset = 4'h3;
    cyc(3);
    chk("outs", outs, 16'h00DC);
    $display("test clock generator done");
    wr(ADR_IO_PAD_CONFIG, 16'h0001);
    wr(ADR_LOGIC_ENABLE_CONFIG, 16'h0001);
    wr(ADR_PIXEL_ARRAY_POWER, 16'h0001);
    chk("outs", outs, 16'h01DF);
    xfer(ADR_PIXEL_ARRAY_POWER, 1'b1, 16'h0000, 20, rv);
    chk("outs", outs, 16'h01DF);
    rd("unmapped", 9'h030, 16'h0000);
    $display("test power done");
    reset_n = 0;
    cyc(2);
    chk("outs", outs, 16'h0020);
    reset_n = 1;
    cyc(8);
    rd("cgen", ADR_CLOCK_GEN_CONFIG, 16'h0004);
    $display("test second reset done");
    finish_test;
  end
endmodule : testbench
